// [pkg/dbw_pkg.sv]
// Purpose: constants and carriers of the downstream window bars
// Assumes: 32-bit APB data, byte offsets on paddr
// Notes:   setup and translated-base words come from config logic
package dbw_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFF_WIN1    = 8'h18;
  localparam logic [7:0] OFF_WIN2    = 8'h1C;
  localparam logic [7:0] OFF_WIN3    = 8'h20;
  localparam logic [7:0] OFF_WIN3_UP = 8'h24;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int SPACE_BIT = 0;
  localparam int TYPE_LO   = 1;
  localparam int TYPE_HI   = 2;
  localparam int PREF_BIT  = 3;
  localparam int RSV_LO    = 4;
  localparam int RSV_HI    = 11;
  localparam int BASE_LO   = 12;
  localparam int EN_BIT    = 31;
  localparam int IO_LO     = 6;
  localparam logic [1:0]  TYPE_32  = 2'h0;
  localparam logic [1:0]  TYPE_64  = 2'h1;
  localparam logic [19:0] BASE_RST = 20'h00000;
  localparam logic [31:0] UP_RST   = 32'h00000000;
  localparam logic [31:0] ZERO32   = 32'h00000000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] setup;
    logic [31:0] xlat;
  } dbw_win_cfg_s;

  typedef struct packed {
    logic        valid;
    logic        io;
    logic [63:0] addr;
  } dbw_req_s;

  typedef struct packed {
    logic [2:0]  hit;
    logic [63:0] addr;
  } dbw_fwd_s;

  typedef enum logic [1:0] {
    DBW_IDLE = 2'b01,
    DBW_RESP = 2'b10
  } dbw_apb_e;

endpackage

// [rtl/dbw_downstream_window_bars.sv]
// Purpose: base address registers of three downstream windows
// Assumes: setup/translated words and requests share pclk
// Notes:   one wait state on every APB access
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps

// Function
// - window 1/3 space and type bits
// - window 2 reports 32-bit type only
// - bit 3 reports prefetchable
// - window 1 size/type from setup
// - base bit writable only where setup set
// - setup bit 31 zero disables window 1/2
// - window 1: 4KB-2GB memory, 64B-2GB IO
// - window 1 hits translated by its base
// - window 2 size from setup, type fixed 32-bit
// - window 2 hits translated by its base
// - window 2: 4KB to 2GB memory
// - window 3 size/type from setup
// - window 3 off when both bit 31 zero
// - window 3: 4KB up to 8EB
// - window 3 32-bit hits translated
// - window 3 64-bit hits pass untranslated
// - upper base word for window 3
module dbw_downstream_window_bars (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire dbw_pkg::dbw_win_cfg_s cfg1,
  input  wire dbw_pkg::dbw_win_cfg_s cfg2,
  input  wire dbw_pkg::dbw_win_cfg_s cfg3,
  input  wire logic [31:0]         setup3_hi,
  input  wire dbw_pkg::dbw_req_s   req,
  output dbw_pkg::dbw_fwd_s        fwd
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // reserved address types read back as 32-bit
  function automatic logic [1:0] fix_type(
    input logic [1:0] t
  );
    fix_type = (t == dbw_pkg::TYPE_64) ? t
             : dbw_pkg::TYPE_32;
  endfunction

  function automatic logic [31:0] bar_word(
    input logic        en,
    input logic [3:0]  attr,
    input logic [19:0] base
  );
    bar_word = en ? {base, 8'h00, attr}
                  : dbw_pkg::ZERO32;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [31:0] m
  );
    merge = (old & ~m) | (nw & m);
  endfunction

  // ----------------------------------------
  // setup decode
  // ----------------------------------------
  logic [19:0] base1;
  logic [19:0] base2;
  logic [19:0] base3;
  logic [31:0] base3_up;
  wire  [19:0] mask1;
  wire  [19:0] mask2;
  wire  [19:0] mask3;
  wire         en1;
  wire         en2;
  wire         en3;
  wire         io1;
  wire         w64;
  wire  [3:0]  attr1;
  wire  [3:0]  attr2;
  wire  [3:0]  attr3;

  // size comes from the writable mask: 4KB granules
  // up to bit 31, and 64-bit in window 3 via setup3_hi
  assign mask1 = cfg1.setup[31:dbw_pkg::BASE_LO];
  assign mask2 = cfg2.setup[31:dbw_pkg::BASE_LO];
  assign mask3 = cfg3.setup[31:dbw_pkg::BASE_LO];
  assign en1 = cfg1.setup[dbw_pkg::EN_BIT];
  assign en2 = cfg2.setup[dbw_pkg::EN_BIT];
  assign en3 = cfg3.setup[dbw_pkg::EN_BIT]
             | setup3_hi[dbw_pkg::EN_BIT];
  assign io1 = cfg1.setup[dbw_pkg::SPACE_BIT];
  assign w64 = fix_type(cfg3.setup[dbw_pkg::TYPE_HI:
                                   dbw_pkg::TYPE_LO])
             == dbw_pkg::TYPE_64;

  assign attr1 = {cfg1.setup[dbw_pkg::PREF_BIT],
                  fix_type(cfg1.setup[dbw_pkg::TYPE_HI:
                                      dbw_pkg::TYPE_LO]),
                  io1};
  assign attr2 = {cfg2.setup[dbw_pkg::PREF_BIT],
                  dbw_pkg::TYPE_32, 1'b0};
  assign attr3 = {cfg3.setup[dbw_pkg::PREF_BIT],
                  fix_type(cfg3.setup[dbw_pkg::TYPE_HI:
                                      dbw_pkg::TYPE_LO]),
                  cfg3.setup[dbw_pkg::SPACE_BIT]};

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  dbw_pkg::dbw_apb_e state;
  dbw_pkg::dbw_apb_e next_state;
  wire        sel1;
  wire        sel2;
  wire        sel3;
  wire        sel3u;
  wire        mapped;
  wire        wr_ok;
  wire        take;
  wire [31:0] rd_word;

  assign sel1   = paddr == dbw_pkg::OFF_WIN1;
  assign sel2   = paddr == dbw_pkg::OFF_WIN2;
  assign sel3   = paddr == dbw_pkg::OFF_WIN3;
  assign sel3u  = paddr == dbw_pkg::OFF_WIN3_UP;
  assign mapped = sel1 | sel2 | sel3 | sel3u;
  assign take   = psel & penable & ~pready
                & (state == dbw_pkg::DBW_IDLE);
  assign wr_ok  = psel & penable & pready & pwrite & mapped;

  // reserved bits 11:4 are constant zero in bar_word
  assign rd_word =
      sel1  ? bar_word(en1, attr1, base1)
    : sel2  ? bar_word(en2, attr2, base2)
    : sel3  ? bar_word(en3, attr3, base3)
    : sel3u ? ((en3 & w64) ? base3_up : dbw_pkg::ZERO32)
    : dbw_pkg::ZERO32;

  always_comb begin
    case (state)
      dbw_pkg::DBW_IDLE: begin
        next_state = take ? dbw_pkg::DBW_RESP
                          : dbw_pkg::DBW_IDLE;
      end
      dbw_pkg::DBW_RESP: begin
        next_state = dbw_pkg::DBW_IDLE;
      end
      default: begin
        next_state = dbw_pkg::DBW_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= dbw_pkg::DBW_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= dbw_pkg::ZERO32;
    end else begin
      state   <= next_state;
      pready  <= take;
      pslverr <= take & ~mapped;
      if (take && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  // ----------------------------------------
  // base registers
  // ----------------------------------------
  // a write only lands on bits that setup opened,
  // and a disabled window ignores writes entirely
  wire [31:0] m1w;
  wire [31:0] m2w;
  wire [31:0] m3w;
  wire [31:0] n1;
  wire [31:0] n2;
  wire [31:0] n3;

  assign m1w = {mask1, 12'h000};
  assign m2w = {mask2, 12'h000};
  assign m3w = {mask3, 12'h000};
  assign n1 = merge({base1, 12'h000}, pwdata, m1w);
  assign n2 = merge({base2, 12'h000}, pwdata, m2w);
  assign n3 = merge({base3, 12'h000}, pwdata, m3w);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base1    <= dbw_pkg::BASE_RST;
      base2    <= dbw_pkg::BASE_RST;
      base3    <= dbw_pkg::BASE_RST;
      base3_up <= dbw_pkg::UP_RST;
    end else if (wr_ok) begin
      if (sel1 && en1) begin
        base1 <= n1[31:dbw_pkg::BASE_LO];
      end
      if (sel2 && en2) begin
        base2 <= n2[31:dbw_pkg::BASE_LO];
      end
      if (sel3 && en3) begin
        base3 <= n3[31:dbw_pkg::BASE_LO];
      end
      if (sel3u && en3 && w64) begin
        base3_up <= merge(base3_up, pwdata, setup3_hi);
      end
    end
  end

  // ----------------------------------------
  // window decode and translation
  // ----------------------------------------
  wire [31:0] a_lo;
  wire [31:0] a_hi;
  wire [31:0] io_m;
  wire [31:0] dm1;
  wire        hit1;
  wire        hit2;
  wire        hit3;
  wire [2:0]  sel_w;
  wire [31:0] x1;
  wire [31:0] x2;
  wire [31:0] x3;
  wire [63:0] next_addr;

  assign a_lo = req.addr[31:0];
  assign a_hi = req.addr[63:32];
  // io windows open bits 11:6 too; base low bits stay
  // zero, so an io window sits on a 4KB boundary
  assign io_m = {20'h00000, cfg1.setup[11:dbw_pkg::IO_LO],
                 6'h00};
  assign dm1  = io1 ? (m1w | io_m) : m1w;

  assign hit1 = en1 & (req.io == io1)
              & (a_hi == dbw_pkg::ZERO32)
              & (((a_lo ^ {base1, 12'h000}) & dm1) == 0);
  assign hit2 = en2 & ~req.io
              & (a_hi == dbw_pkg::ZERO32)
              & (((a_lo ^ {base2, 12'h000}) & m2w) == 0);
  assign hit3 = en3 & ~req.io
              & (w64 ? (((a_hi ^ base3_up) & setup3_hi) == 0)
                     : (a_hi == dbw_pkg::ZERO32))
              & (((a_lo ^ {base3, 12'h000}) & m3w) == 0);

  // overlapping windows resolve in window order
  assign sel_w = hit1 ? 3'b001
               : hit2 ? 3'b010
               : hit3 ? 3'b100
               : 3'b000;

  assign x1 = merge(a_lo, cfg1.xlat, dm1);
  assign x2 = merge(a_lo, cfg2.xlat, m2w);
  assign x3 = merge(a_lo, cfg3.xlat, m3w);

  assign next_addr =
      sel_w[0] ? {dbw_pkg::ZERO32, x1}
    : sel_w[1] ? {dbw_pkg::ZERO32, x2}
    : (sel_w[2] && !w64) ? {dbw_pkg::ZERO32, x3}
    : req.addr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd <= '0;
    end else begin
      fwd.hit  <= req.valid ? sel_w : 3'b000;
      fwd.addr <= next_addr;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  apb_answer_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    take |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  win2_type_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready && !pwrite && sel2 |-> prdata[2:1] == 2'b00)
    else $error("window 2 type not 32-bit");

  // the upper base word is address bits throughout
  rsv_zero_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready && !pwrite && !sel3u |-> prdata[11:4] == 8'h00)
    else $error("reserved bits not zero");

  dis_read_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    take && !pwrite && sel1 && !en1
    |=> prdata == 32'h00000000)
    else $error("disabled window 1 reads nonzero");

  ro_bits_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_ok && sel1
    |=> ((base1 ^ $past(base1)) & ~$past(mask1)) == 0)
    else $error("read-only base bit changed");

  no_claim_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    req.valid && !en2 |=> !fwd.hit[1])
    else $error("disabled window 2 claimed");

  claim_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    req.valid && hit1 |=> fwd.hit == 3'b001)
    else $error("window 1 hit not claimed");

  pass64_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    sel_w == 3'b100 && w64
    |=> fwd.addr == $past(req.addr))
    else $error("64-bit window 3 address altered");

  xlat2_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    sel_w == 3'b010
    |=> ((fwd.addr[31:0] ^ $past(cfg2.xlat))
         & $past(m2w)) == 0)
    else $error("window 2 not translated");

  upper_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_ok && sel3u && en3 && w64
    |=> ((base3_up ^ $past(pwdata)) & $past(setup3_hi)) == 0)
    else $error("upper base not written");

endmodule

// [tb/dbw_host_model.sv]
// Purpose: primary-side host, APB master and address lookups
// Assumes: slave answers with pready; fwd lands one edge after req
// Notes:   released address, data and req lines carry inverted values; pwrite keeps its last one
`timescale 1ns/100ps
module dbw_host_model (
  input  wire logic              pclk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic [7:0]             paddr,
  output logic [31:0]            pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  output dbw_pkg::dbw_req_s      req,
  input  wire dbw_pkg::dbw_fwd_s fwd
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = '0;
  end

  // ----------------------------------------
  // apb transfer, held until pready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e, output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  // ----------------------------------------
  // one lookup, answer one edge later
  // ----------------------------------------
  task automatic look(input dbw_pkg::dbw_req_s q,
                      output dbw_pkg::dbw_fwd_s f);
    @(posedge pclk);
    req <= q;
    @(posedge pclk);
    req <= '{1'b0, ~q.io, ~q.addr};
    // fwd was launched at the edge above; settled by now
    @(negedge pclk);
    f = fwd;
  endtask
endmodule

// [tb/downstream_window_bars_tb_top.sv]
// Purpose: self-checking bench of the downstream window bars
// Assumes: window setup words are driven here in place of config logic
// Notes:   table rows first, then disable, type change and reset cases
`timescale 1ns/100ps
module downstream_window_bars_tb_top;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } dbw_row_s;
  typedef struct packed {
    dbw_pkg::dbw_req_s q;
    dbw_pkg::dbw_fwd_s f;
  } dbw_look_s;

  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  dbw_pkg::dbw_win_cfg_s cfg1;
  dbw_pkg::dbw_win_cfg_s cfg2;
  dbw_pkg::dbw_win_cfg_s cfg3;
  logic [31:0]          setup3_hi;
  dbw_pkg::dbw_req_s    req;
  dbw_pkg::dbw_fwd_s    fwd;
  int                   errors;
  int                   check_count;
  logic [31:0]          rd;
  logic                 er;

  dbw_row_s rows [5] = '{
    '{8'h18, 32'hFFFF_FFFF, 32'hFFFF_0008, 1'b0},
    '{8'h1C, 32'h1234_5678, 32'h1230_0000, 1'b0},
    '{8'h20, 32'hABCD_E123, 32'hABCD_E002, 1'b0},
    '{8'h24, 32'h0000_0155, 32'h0000_0055, 1'b0},
    '{8'h28, 32'h0000_0000, 32'h0000_0000, 1'b1}};
  dbw_look_s looks [5] = '{
    '{'{1'b1, 1'b0, 64'hFFFF_1234}, '{3'b001, 64'h1111_1234}},
    '{'{1'b1, 1'b0, 64'h1234_5678}, '{3'b010, 64'h4564_5678}},
    '{'{1'b1, 1'b0, 64'h55_ABCD_E9A0}, '{3'b100, 64'h55_ABCD_E9A0}},
    '{'{1'b1, 1'b1, 64'hFFFF_1234}, '{3'b000, 64'hFFFF_1234}},
    '{'{1'b1, 1'b0, 64'h1000}, '{3'b000, 64'h1000}}};

  dbw_downstream_window_bars dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg1(cfg1), .cfg2(cfg2), .cfg3(cfg3),
    .setup3_hi(setup3_hi), .req(req), .fwd(fwd));
  dbw_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req(req), .fwd(fwd));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------
  // compare, verdict and bus helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [71:0] s, x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic to;
    host.xfer(w, a, d, rd, er, to);
    chk("apb_timeout", to, 1'b0);
    if (to) begin
      end_of_test();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk("prdata", rd, x);
  endtask

  task automatic lk(input dbw_pkg::dbw_req_s q, dbw_pkg::dbw_fwd_s x);
    dbw_pkg::dbw_fwd_s f;
    host.look(q, f);
    chk("fwd", f, x);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    check_count = 0;
    presetn = 1'b0;
    // window 2 asks for io and a reserved type; both must read as 0
    cfg1 = '{32'hFFFF_0008, 32'h1111_0000};
    cfg2 = '{32'hFFF0_0007, 32'h4560_0000};
    cfg3 = '{32'hFFFF_F002, 32'h7777_7000};
    setup3_hi = 32'h8000_00FF;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(8'h18, 32'h0000_0008);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, rows[i].a, rows[i].d);
      chk("wr_err", er, rows[i].e);
      acc(1'b0, rows[i].a, 32'h0);
      chk("rd_err", er, rows[i].e);
      if (!rows[i].e) begin
        chk("row", rd, rows[i].x);
      end
    end
    for (int i = 0; i < 5; i++) begin
      lk(looks[i].q, looks[i].f);
    end
    @(posedge pclk);
    cfg2.setup[31] <= 1'b0;
    rchk(8'h1C, 32'h0);
    acc(1'b1, 8'h1C, 32'hFFFF_FFFF);
    lk(looks[1].q, '{3'b000, 64'h1234_5678});
    @(posedge pclk);
    cfg2.setup[31] <= 1'b1;
    rchk(8'h1C, 32'h1230_0000);
    @(posedge pclk);
    cfg3.setup[31] <= 1'b0;
    rchk(8'h20, 32'hABCD_E002);
    @(posedge pclk);
    setup3_hi[31] <= 1'b0;
    rchk(8'h20, 32'h0);
    rchk(8'h24, 32'h0);
    @(posedge pclk);
    setup3_hi[31] <= 1'b1;
    cfg3.setup[31] <= 1'b1;
    // 32-bit mode on window 3: translation is back, upper word reads 0
    cfg3.setup[2:1] <= 2'b00;
    lk('{1'b1, 1'b0, 64'hABCD_E9A0},
       '{3'b100, 64'h7777_79A0});
    rchk(8'h20, 32'hABCD_E000);
    rchk(8'h24, 32'h0);
    // window 1 as an io window with 64B granules, then switched off
    @(posedge pclk);
    cfg1.setup <= 32'hFFFF_FFC1;
    rchk(8'h18, 32'hFFFF_0001);
    lk('{1'b1, 1'b1, 64'hFFFF_0012},
       '{3'b001, 64'h1111_0012});
    @(posedge pclk);
    cfg1.setup[31] <= 1'b0;
    rchk(8'h18, 32'h0);
    lk('{1'b1, 1'b1, 64'hFFFF_0012},
       '{3'b000, 64'hFFFF_0012});
    @(posedge pclk);
    cfg1.setup <= 32'hFFFF_0008;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk("fwd_rst", fwd, 67'h0);
    presetn <= 1'b1;
    rchk(8'h18, 32'h0000_0008);
    rchk(8'h1C, 32'h0);
    end_of_test();
  end
endmodule
